// file: core/swgc_pkg.sv
// Purpose: constants and types for the switch global configuration bank
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half
// Notes:   register index times four gives the byte address
package swgc_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // ------------------------------------------------------------------
    // register index and byte address
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_GLOBAL_CTL7 = 8'h0e;
    localparam logic [7:0] IDX_PAUSE_HIGH  = 8'h10;
    localparam logic [7:0] IDX_PAUSE_MID   = 8'h12;
    localparam logic [7:0] IDX_PAUSE_LOW   = 8'h14;
    localparam logic [7:0] IDX_DSCP_MAP0   = 8'h16;

    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CTL7 =
        ADDR_W'(IDX_GLOBAL_CTL7 * 4);
    localparam logic [ADDR_W-1:0] ADDR_PAUSE_HIGH  =
        ADDR_W'(IDX_PAUSE_HIGH * 4);
    localparam logic [ADDR_W-1:0] ADDR_PAUSE_MID   =
        ADDR_W'(IDX_PAUSE_MID * 4);
    localparam logic [ADDR_W-1:0] ADDR_PAUSE_LOW   =
        ADDR_W'(IDX_PAUSE_LOW * 4);
    localparam logic [ADDR_W-1:0] ADDR_DSCP_MAP0   =
        ADDR_W'(IDX_DSCP_MAP0 * 4);

    // ------------------------------------------------------------------
    // global control 7 fields
    // ------------------------------------------------------------------
    localparam int DRV_LSB     = 5;
    localparam int UNK_EN_BIT  = 7;
    localparam int UNK_MSK_LSB = 0;
    localparam logic [15:0] GCTL_WMASK = 16'h00e7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  DRV_RST_STD   = 2'h1;
    localparam logic [1:0]  DRV_RST_LOWV  = 2'h2;
    localparam logic        UNK_EN_RST    = 1'b0;
    localparam logic [2:0]  UNK_MSK_RST   = 3'h7;
    localparam logic [15:0] PAUSE_LOW_RST = 16'hffff;
    localparam logic [15:0] DSCP_MAP0_RST = 16'h0000;

    // ------------------------------------------------------------------
    // drive current in mA per code, ports and responses
    // ------------------------------------------------------------------
    localparam logic [4:0] DRV_MA_0 = 5'h04;
    localparam logic [4:0] DRV_MA_1 = 5'h08;
    localparam logic [4:0] DRV_MA_2 = 5'h0c;
    localparam logic [4:0] DRV_MA_3 = 5'h10;
    localparam logic [2:0] ALL_PORTS   = 3'h7;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] driveSel;
        logic [4:0] driveMa;
        logic       unkEn;
        logic [2:0] unkMask;
    } swgc_io_cfg_t;

    typedef struct packed {
        logic       valid;
        logic       maskApplied;
        logic [2:0] ports;
    } swgc_fwd_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } swgc_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } swgc_rd_state_t;

endpackage

// file: core/swgc_prio_lookup.sv
// Purpose: maps a TOS / traffic class byte to a frame priority
// Assumes: map holds one PRIO_W field per code point, code point 0 lowest
// Notes:   one cycle from request to registered result
`timescale 1ns/1ps
module swgc_prio_lookup
    import swgc_pkg::*;
#(
    parameter int CP_W   = 6,
    parameter int PRIO_W = 2
) (
    // clock, reset, enable
    input  wire logic                            clk,
    input  wire logic                            reset_n,
    input  wire logic                            ce,
    // request
    input  wire logic                            tosValid,
    input  wire logic [7:0]                      tosByte,
    input  wire logic [(PRIO_W<<CP_W)-1:0]       prioMap,
    // result
    output logic                                 prioValid_q,
    output logic [PRIO_W-1:0]                    prio_q
);
    // ------------------------------------------------------------------
    // code point select
    // ------------------------------------------------------------------
    wire logic [CP_W-1:0]   codePoint = tosByte[7 -: CP_W];
    wire logic [PRIO_W-1:0] prioSel   =
        prioMap[codePoint*PRIO_W +: PRIO_W];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prioValid_q <= 1'b0;
            prio_q      <= '0;
        end else if (ce) begin
            prioValid_q <= tosValid;
            if (tosValid) begin
                prio_q <= prioSel;
            end
        end
    end
endmodule // swgc_prio_lookup

// file: core/swgc_regs.sv
// Purpose: switch global configuration register bank over AXI4-Lite
// Assumes: inputs synchronous to clk; ce low freezes all state
// Notes:   16-bit registers in the low half of each 32-bit word
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module swgc_regs
    import swgc_pkg::*;
#(
    // pause address reset high and mid words, values arbitrary
    parameter logic [15:0] PAUSE_HIGH_RST = 16'h0200,
    parameter logic [15:0] PAUSE_MID_RST  = 16'h0000,
    parameter int          UPPER_MAP_W    = 112
) (
    // clock, reset, enable
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    ce,
    // supply strap, high for 1.8 V I/O
    input  wire logic                    ioSupply18,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0]       s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]            s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // pad configuration
    output swgc_io_cfg_t                 ioCfg_q,
    // unknown destination forwarding
    input  wire logic                    unkLookupValid,
    output swgc_fwd_t                    unkFwd_q,
    // dscp classification
    input  wire logic                    tosValid,
    input  wire logic [7:0]              tosByte,
    input  wire logic [UPPER_MAP_W-1:0]  upperDscpMap,
    output logic                         prioValid_q,
    output logic [1:0]                   prio_q,
    // pause frame source address bytes
    input  wire logic [2:0]              pauseByteIdx,
    output logic [7:0]                   pauseSaByte_q
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    swgc_wr_state_t      wrState_q;
    swgc_wr_state_t      wrState_d;
    swgc_rd_state_t      rdState_q;
    swgc_rd_state_t      rdState_d;
    logic                awRdy_q;
    logic                wRdy_q;
    logic                arRdy_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [1:0]          rresp_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [ADDR_W-1:0]   wrAddr_q;
    logic [REG_W-1:0]    wrData_q;
    logic [1:0]          wrStrb_q;
    logic [REG_W-1:0]    gctl_q;
    logic [REG_W-1:0]    pauseHigh_q;
    logic [REG_W-1:0]    pauseMid_q;
    logic [REG_W-1:0]    pauseLow_q;
    logic [REG_W-1:0]    dscpMap0_q;

    // ------------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awRdy_q;
    assign s_axi_wready  = wRdy_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arRdy_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // ------------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------------
    wire logic awTake = s_axi_awvalid & awRdy_q;
    wire logic wTake  = s_axi_wvalid & wRdy_q;
    wire logic bDone  = bvalid_q & s_axi_bready;
    wire logic arTake = s_axi_arvalid & arRdy_q;
    wire logic rDone  = rvalid_q & s_axi_rready;
    wire logic wrGo   = ~awRdy_q & ~wRdy_q & (wrState_q == WR_IDLE);

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    wire logic wHitGctl  = (wrAddr_q == ADDR_GLOBAL_CTL7);
    wire logic wHitHigh  = (wrAddr_q == ADDR_PAUSE_HIGH);
    wire logic wHitMid   = (wrAddr_q == ADDR_PAUSE_MID);
    wire logic wHitLow   = (wrAddr_q == ADDR_PAUSE_LOW);
    wire logic wHitMap0  = (wrAddr_q == ADDR_DSCP_MAP0);
    wire logic wHitAny   =
        wHitGctl | wHitHigh | wHitMid | wHitLow | wHitMap0;
    wire logic [REG_W-1:0] laneMask =
        {{8{wrStrb_q[1]}}, {8{wrStrb_q[0]}}};
    wire logic [REG_W-1:0] gctlMask = laneMask & GCTL_WMASK;

    // ------------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------------
    wire logic [REG_W-1:0] gctlNext =
        (gctl_q & ~gctlMask) | (wrData_q & gctlMask);
    wire logic [REG_W-1:0] highNext =
        (pauseHigh_q & ~laneMask) | (wrData_q & laneMask);
    wire logic [REG_W-1:0] midNext =
        (pauseMid_q & ~laneMask) | (wrData_q & laneMask);
    wire logic [REG_W-1:0] lowNext =
        (pauseLow_q & ~laneMask) | (wrData_q & laneMask);
    wire logic [REG_W-1:0] map0Next =
        (dscpMap0_q & ~laneMask) | (wrData_q & laneMask);

    // drive default follows the supply strap at reset
    wire logic [1:0] driveRst =
        ioSupply18 ? DRV_RST_LOWV : DRV_RST_STD;
    wire logic [REG_W-1:0] gctlRst =
        REG_W'({UNK_EN_RST, driveRst, 2'h0, UNK_MSK_RST});

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    wire logic rHitGctl = (s_axi_araddr == ADDR_GLOBAL_CTL7);
    wire logic rHitHigh = (s_axi_araddr == ADDR_PAUSE_HIGH);
    wire logic rHitMid  = (s_axi_araddr == ADDR_PAUSE_MID);
    wire logic rHitLow  = (s_axi_araddr == ADDR_PAUSE_LOW);
    wire logic rHitMap0 = (s_axi_araddr == ADDR_DSCP_MAP0);
    wire logic rHitAny  =
        rHitGctl | rHitHigh | rHitMid | rHitLow | rHitMap0;
    wire logic [REG_W-1:0] rdSel =
        ({REG_W{rHitGctl}} & gctl_q) |
        ({REG_W{rHitHigh}} & pauseHigh_q) |
        ({REG_W{rHitMid}}  & pauseMid_q) |
        ({REG_W{rHitLow}}  & pauseLow_q) |
        ({REG_W{rHitMap0}} & dscpMap0_q);

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    wire logic [1:0] driveSel = gctl_q[DRV_LSB +: 2];
    wire logic       unkEn    = gctl_q[UNK_EN_BIT];
    wire logic [2:0] unkMask  = gctl_q[UNK_MSK_LSB +: 3];
    wire logic [47:0] pauseAddr =
        {pauseHigh_q, pauseMid_q, pauseLow_q};
    wire logic [7:0] pauseByteSel =
        (pauseByteIdx < 3'h6) ?
        pauseAddr[8'(47 - 8*pauseByteIdx) -: 8] : 8'h00;
    wire logic [127:0] fullMap = {upperDscpMap, dscpMap0_q};

    // drive code to milliamps
    logic [4:0] driveMa;
    always_comb begin
        case (driveSel)
            2'h0:    driveMa = DRV_MA_0;
            2'h1:    driveMa = DRV_MA_1;
            2'h2:    driveMa = DRV_MA_2;
            default: driveMa = DRV_MA_3;
        endcase
    end

    // ------------------------------------------------------------------
    // write state machine
    // ------------------------------------------------------------------
    always_comb begin
        wrState_d = wrState_q;
        case (wrState_q)
            WR_IDLE: begin
                if (wrGo) begin
                    wrState_d = WR_RESP;
                end
            end
            WR_RESP: begin
                if (bDone) begin
                    wrState_d = WR_IDLE;
                end
            end
            default: wrState_d = WR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wrState_q <= WR_IDLE;
            awRdy_q   <= 1'b1;
            wRdy_q    <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            wrAddr_q  <= '0;
            wrData_q  <= '0;
            wrStrb_q  <= '0;
        end else if (ce) begin
            wrState_q <= wrState_d;
            if (awTake) begin
                awRdy_q  <= 1'b0;
                wrAddr_q <= s_axi_awaddr;
            end else if (bDone) begin
                awRdy_q <= 1'b1;
            end
            if (wTake) begin
                wRdy_q   <= 1'b0;
                wrData_q <= s_axi_wdata[REG_W-1:0];
                wrStrb_q <= s_axi_wstrb[1:0];
            end else if (bDone) begin
                wRdy_q <= 1'b1;
            end
            if (wrGo) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wHitAny ? RESP_OKAY : RESP_SLVERR;
            end else if (bDone) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gctl_q      <= gctlRst;
            pauseHigh_q <= PAUSE_HIGH_RST;
            pauseMid_q  <= PAUSE_MID_RST;
            pauseLow_q  <= PAUSE_LOW_RST;
            dscpMap0_q  <= DSCP_MAP0_RST;
        end else if (ce && wrGo) begin
            if (wHitGctl) begin
                gctl_q <= gctlNext;
            end
            if (wHitHigh) begin
                pauseHigh_q <= highNext;
            end
            if (wHitMid) begin
                pauseMid_q <= midNext;
            end
            if (wHitLow) begin
                pauseLow_q <= lowNext;
            end
            if (wHitMap0) begin
                dscpMap0_q <= map0Next;
            end
        end
    end

    // ------------------------------------------------------------------
    // read state machine
    // ------------------------------------------------------------------
    always_comb begin
        rdState_d = rdState_q;
        case (rdState_q)
            RD_IDLE: begin
                if (arTake) begin
                    rdState_d = RD_RESP;
                end
            end
            RD_RESP: begin
                if (rDone) begin
                    rdState_d = RD_IDLE;
                end
            end
            default: rdState_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdState_q <= RD_IDLE;
            arRdy_q   <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= '0;
        end else if (ce) begin
            rdState_q <= rdState_d;
            if (arTake) begin
                arRdy_q  <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q  <= rHitAny ? RESP_OKAY : RESP_SLVERR;
                rdata_q  <= DATA_W'(rdSel);
            end else if (rDone) begin
                arRdy_q  <= 1'b1;
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration and forwarding outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ioCfg_q       <= '0;
            unkFwd_q      <= '0;
            pauseSaByte_q <= '0;
        end else if (ce) begin
            ioCfg_q.driveSel <= driveSel;
            ioCfg_q.driveMa  <= driveMa;
            ioCfg_q.unkEn    <= unkEn;
            ioCfg_q.unkMask  <= unkMask;
            unkFwd_q.valid   <= unkLookupValid;
            if (unkLookupValid) begin
                unkFwd_q.maskApplied <= unkEn;
                unkFwd_q.ports <= unkEn ? unkMask : ALL_PORTS;
            end
            pauseSaByte_q <= pauseByteSel;
        end
    end

    // ------------------------------------------------------------------
    // dscp priority lookup
    // ------------------------------------------------------------------
    swgc_prio_lookup #(
        .CP_W   (6),
        .PRIO_W (2)
    ) u_prio (
        .clk         (clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .tosValid    (tosValid),
        .tosByte     (tosByte),
        .prioMap     (fullMap),
        .prioValid_q (prioValid_q),
        .prio_q      (prio_q)
    );

endmodule // swgc_regs

// file: dv/swgc_regs_checker.sv
// Purpose: port-level properties of the configuration register bank
// Assumes: ce held high by the bench
// Notes:   bound to swgc_regs from the bench top file
`timescale 1ns/1ps
module swgc_regs_checker
    import swgc_pkg::*;
(
    // clock and reset
    input logic         clk,
    input logic         reset_n,
    // register bus
    input logic         s_axi_awvalid,
    input logic         s_axi_awready,
    input logic         s_axi_wvalid,
    input logic         s_axi_wready,
    input logic         s_axi_bvalid,
    input logic         s_axi_arvalid,
    input logic         s_axi_arready,
    input logic         s_axi_rvalid,
    input logic [31:0]  s_axi_rdata,
    // datapath side
    input swgc_io_cfg_t ioCfg_q,
    input logic         unkLookupValid,
    input swgc_fwd_t    unkFwd_q,
    input logic         tosValid,
    input logic         prioValid_q,
    input logic [2:0]   pauseByteIdx,
    input logic [7:0]   pauseSaByte_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_drv;
        $past(reset_n) |->
            ioCfg_q.driveMa == {1'b0, ioCfg_q.driveSel, 2'b00} + 5'h04;
    endproperty
    a_drv: assert property (p_drv)
        else $error("drive current does not follow code");
    property p_unk;
        unkLookupValid |=> unkFwd_q.valid
            && unkFwd_q.maskApplied == ioCfg_q.unkEn
            && unkFwd_q.ports == (ioCfg_q.unkEn ? ioCfg_q.unkMask : 3'h7);
    endproperty
    a_unk: assert property (p_unk)
        else $error("unknown destination port set wrong");
    property p_unkIdle;
        !unkLookupValid |=> !unkFwd_q.valid;
    endproperty
    a_unkIdle: assert property (p_unkIdle)
        else $error("forwarding result without lookup");
    property p_prio;
        1'b1 |=> prioValid_q == $past(tosValid);
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority result timing wrong");
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |-> ##2 s_axi_bvalid;
    endproperty
    a_wr: assert property (p_wr)
        else $error("write response late");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data late");
    property p_bwait;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_bwait: assert property (p_bwait)
        else $error("write accepted before response taken");
    property p_rwait;
        s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_rwait: assert property (p_rwait)
        else $error("read channel state wrong");
    property p_byte;
        pauseByteIdx[2:1] == 2'b11 |=> pauseSaByte_q == 8'h00;
    endproperty
    a_byte: assert property (p_byte)
        else $error("pause byte beyond address not zero");
endmodule // swgc_regs_checker

// file: dv/swgc_regs_bench.sv
// Purpose: directed bench for the configuration register bank
// Assumes: ce tied high, bus tasks speak AXI4-Lite
// Notes:   expectations come from field layout and reset values
`timescale 1ns/1ps
module swgc_regs_bench;
    import swgc_pkg::*;
    logic         clk = 0, reset_n = 0, ce = 1, ioSupply18 = 0;
    logic [7:0]   s_axi_awaddr = 0, s_axi_araddr = 0, tosByte = 0;
    logic [31:0]  s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]   s_axi_wstrb = 0;
    logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic         s_axi_arvalid = 0, s_axi_rready = 0;
    logic [2:0]   prot = 0, pauseByteIdx = 0;
    logic         unkLookupValid = 0, tosValid = 0, prioValid_q;
    logic [111:0] upperDscpMap = {2'b01, {54{2'b10}}, 2'b11};
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, prio_q, rsp;
    logic [7:0]   pauseSaByte_q;
    logic [47:0]  mac = 48'h1a2b_3c4d_5e6f;
    swgc_io_cfg_t ioCfg_q;
    swgc_fwd_t    unkFwd_q;
    int           errorCnt = 0, checked = 0;

    always #5 clk = ~clk;

    swgc_regs uut (.clk, .reset_n, .ce, .ioSupply18, .s_axi_awaddr,
        .s_axi_awprot(prot), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ioCfg_q, .unkLookupValid, .unkFwd_q,
        .tosValid, .tosByte, .upperDscpMap, .prioValid_q, .prio_q,
        .pauseByteIdx, .pauseSaByte_q);

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errorCnt++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic axWr(input logic [7:0] a, input logic [15:0] d,
                        input logic [3:0] s = 4'h3);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
        #1;
    endtask
    task automatic axRd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        axRd(a);
        cmp(e, rd);
    endtask
    task automatic tosChk(input logic [7:0] b, input logic [1:0] e);
        @(posedge clk);
        tosValid <= 1;
        tosByte <= b;
        @(posedge clk);
        tosValid <= 0;
        #1;
        cmp(32'({1'b1, e}), 32'({prioValid_q, prio_q}));
    endtask
    task automatic unkChk(input logic [4:0] e);
        @(posedge clk);
        unkLookupValid <= 1;
        @(posedge clk);
        unkLookupValid <= 0;
        #1;
        cmp(32'(e), 32'(unkFwd_q));
    endtask
    task automatic testDone();
        $display("errors %0d checks %0d", errorCnt, checked);
        if (errorCnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        rdChk(ADDR_GLOBAL_CTL7, 32'h0000_0027);
        rdChk(ADDR_PAUSE_HIGH, 32'h0000_0200);
        rdChk(ADDR_PAUSE_MID, 32'h0000_0000);
        rdChk(ADDR_PAUSE_LOW, 32'h0000_ffff);
        rdChk(ADDR_DSCP_MAP0, 32'h0000_0000);
        cmp(32'h0000_0287, 32'(ioCfg_q));
        for (int c = 0; c < 4; c++) begin
            axWr(ADDR_GLOBAL_CTL7, 16'(c << 5));
            cmp(32'(RESP_OKAY), 32'(rsp));
            cmp(32'((c + 1) * 4), 32'(ioCfg_q.driveMa));
        end
        axWr(ADDR_GLOBAL_CTL7, 16'hffff);
        rdChk(ADDR_GLOBAL_CTL7, 32'h0000_00e7);
        axWr(ADDR_GLOBAL_CTL7, 16'h0005);
        unkChk(5'b10111);
        axWr(ADDR_GLOBAL_CTL7, 16'h0085);
        unkChk(5'b11101);
        axWr(ADDR_DSCP_MAP0, 16'hffff, 4'h1);
        rdChk(ADDR_DSCP_MAP0, 32'h0000_00ff);
        axWr(ADDR_DSCP_MAP0, 16'h1234, 4'h2);
        rdChk(ADDR_DSCP_MAP0, 32'h0000_12ff);
        axWr(ADDR_DSCP_MAP0, 16'he41b);
        for (int p = 0; p < 8; p++)
            tosChk({p[5:0], 2'b11}, 2'(16'he41b >> (2 * p)));
        tosChk(8'h20, 2'b11);
        tosChk(8'hfc, 2'b01);
        axWr(ADDR_PAUSE_HIGH, mac[47:32]);
        axWr(ADDR_PAUSE_MID, mac[31:16]);
        axWr(ADDR_PAUSE_LOW, mac[15:0]);
        cmp(32'(RESP_OKAY), 32'(rsp));
        rdChk(ADDR_PAUSE_HIGH, 32'h0000_1a2b);
        rdChk(ADDR_PAUSE_MID, 32'h0000_3c4d);
        rdChk(ADDR_PAUSE_LOW, 32'h0000_5e6f);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            pauseByteIdx <= 3'(i);
            @(posedge clk);
            #1;
            rd = i < 6 ? 32'(mac[47 - 8 * i -: 8]) : 32'h0000_0000;
            cmp(rd, 32'(pauseSaByte_q));
        end
        axWr(8'h3c, 16'h1234);
        cmp(32'h0000_0002, 32'(rsp));
        rdChk(8'h3c, 32'h0000_0000);
        cmp(32'h0000_0002, 32'(rsp));
        reset_n <= 0;
        ioSupply18 <= 1;
        repeat (4) @(posedge clk);
        reset_n <= 1;
        rdChk(ADDR_GLOBAL_CTL7, 32'h0000_0047);
        cmp(32'h0000_000c, 32'(ioCfg_q.driveMa));
        testDone();
    end

    initial begin
        #100us;
        errorCnt++;
        testDone();
    end
endmodule // swgc_regs_bench

bind swgc_regs swgc_regs_checker chk (.clk, .reset_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .ioCfg_q,
    .unkLookupValid, .unkFwd_q, .tosValid, .prioValid_q, .pauseByteIdx,
    .pauseSaByte_q);
